// [logic/lws_sram_mst.sv]
// Register-driven controller for the late-write SRAM port.
//
// The plain strobed port and the register offsets were decided locally.
module lws_sram_mst (
	input wire logic mclk, // system clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic [lws_pkg::REG_ADDR_W-1:0] reg_addr, // register word address
	input wire logic [lws_pkg::DATA_W-1:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [lws_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
	lws_if.mst port // memory pins
);
	import lws_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic rd_valid;
	logic stall;
	logic flow;
	logic issue;
	logic [1:0] op;
	lws_kind_t burst_kind;
	lws_kind_t next_kind;
	lws_kind_t pin_kind;
	logic [DATA_W-1:0] pin_wdata;
	lws_kind_t s1_kind;
	logic [DATA_W-1:0] s1_wdata;
	lws_kind_t s2_kind;
	logic capture;

	assign stall = ctrl[CTRL_STALL];
	assign flow = ctrl[CTRL_FLOW];
	// Commands written while stalled are dropped; software watches busy.
	assign issue = reg_wr && (reg_addr == REG_CMD) && !stall;
	assign op = reg_wdata[CMD_OP_LSB +: 2];

	always_comb begin
		next_kind = KIND_NONE;
		unique case (op)
			OP_READ: next_kind = KIND_READ;
			OP_WRITE: next_kind = KIND_WRITE;
			OP_BURST: next_kind = burst_kind;
			OP_DESEL: next_kind = KIND_NONE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= CTRL_RESET;
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL) ctrl <= reg_wdata[CTRL_W-1:0];
			if (reg_addr == REG_ADDR) addr_reg <= reg_wdata[ADDR_W-1:0];
			if (reg_addr == REG_WDATA) wdata_reg <= reg_wdata;
		end
	end

	// Pin drive: an idle cycle is a deselect load, so every fresh access
	// goes out with the step input low.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			port.select_low_one <= 1'b1;
			port.select_high <= 1'b0;
			port.select_low_two <= 1'b1;
			port.write_n <= 1'b1;
			port.lane_wr_n <= '1;
			port.burst_step <= 1'b0;
			port.addr <= '0;
			burst_kind <= KIND_NONE;
			pin_kind <= KIND_NONE;
			pin_wdata <= '0;
		end else if (!stall) begin
			port.burst_step <= 1'b0; // R3
			port.select_low_one <= 1'b1;
			port.select_high <= 1'b0;
			port.select_low_two <= 1'b1;
			port.write_n <= 1'b1;
			port.lane_wr_n <= '1;
			pin_kind <= KIND_NONE;
			pin_wdata <= wdata_reg;
			if (issue) begin
				pin_kind <= next_kind;
				port.addr <= addr_reg;
				port.lane_wr_n <= ~reg_wdata[CMD_LANE_LSB +: LANES];
				if (op == OP_BURST) begin
					port.burst_step <= 1'b1;
				end else begin
					burst_kind <= next_kind;
					port.select_low_one <= (op == OP_DESEL);
					port.select_high <= (op != OP_DESEL);
					port.select_low_two <= (op == OP_DESEL);
					port.write_n <= (op != OP_WRITE);
				end
			end
		end
	end

	// Data timing mirrors the device: write data one edge after the command
	// edge in flow-through mode, two when pipelined; reads likewise.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_kind <= KIND_NONE;
			s1_wdata <= '0;
			s2_kind <= KIND_NONE;
			port.mst_dq <= '0;
			port.mst_dq_oe <= 1'b0;
		end else if (!stall) begin
			s1_kind <= pin_kind;
			s1_wdata <= pin_wdata;
			s2_kind <= s1_kind;
			port.mst_dq <= flow ? pin_wdata : s1_wdata; // R13 R11
			port.mst_dq_oe <= flow ? (pin_kind == KIND_WRITE) : (s1_kind == KIND_WRITE); // R13 R11
		end
	end

	assign capture = !stall && (flow ? (s1_kind == KIND_READ) : (s2_kind == KIND_READ));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= '0;
			rd_valid <= 1'b0;
		end else if (capture) begin
			rdata_reg <= port.dq_bus;
			rd_valid <= 1'b1;
		end else if (reg_rd && (reg_addr == REG_RDATA)) begin
			rd_valid <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			unique case (reg_addr)
				REG_CTRL: reg_rdata[CTRL_W-1:0] <= ctrl;
				REG_ADDR: reg_rdata[ADDR_W-1:0] <= addr_reg;
				REG_WDATA: reg_rdata <= wdata_reg;
				REG_RDATA: reg_rdata <= rdata_reg;
				REG_STATUS: begin
					reg_rdata[STAT_RDVALID] <= rd_valid;
					reg_rdata[STAT_BUSY] <= (pin_kind != KIND_NONE) || (s1_kind != KIND_NONE) || (s2_kind != KIND_NONE);
				end
				default: reg_rdata <= '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			port.clk_en_n <= 1'b0;
			port.out_en_n <= 1'b1;
			port.sleep_req <= 1'b0;
			port.linear_order_n <= 1'b0;
			port.unregistered_out_n <= 1'b1;
		end else begin
			port.clk_en_n <= ctrl[CTRL_STALL]; // R1
			port.out_en_n <= !ctrl[CTRL_OE];
			port.sleep_req <= ctrl[CTRL_SLEEP];
			port.linear_order_n <= ctrl[CTRL_INTERLEAVE];
			port.unregistered_out_n <= !ctrl[CTRL_FLOW]; // R22
		end
	end
endmodule // lws_sram_mst

// [shared/lws_pkg.sv]
// Shared constants, types and helpers for the late-write synchronous SRAM port.
package lws_pkg;
	localparam int ADDR_W = 10;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int LSB_W = 2;
	localparam logic [LSB_W-1:0] CNT_START = 2'h0;
	localparam logic [LSB_W-1:0] CNT_STEP = 2'h1;

	// Controller register map, word addresses on the plain register port.
	localparam int REG_ADDR_W = 4;
	localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [REG_ADDR_W-1:0] REG_ADDR = 4'h1;
	localparam logic [REG_ADDR_W-1:0] REG_WDATA = 4'h2;
	localparam logic [REG_ADDR_W-1:0] REG_CMD = 4'h3;
	localparam logic [REG_ADDR_W-1:0] REG_RDATA = 4'h4;
	localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h5;

	// Control register fields.
	localparam int CTRL_W = 5;
	localparam int CTRL_FLOW = 0;
	localparam int CTRL_INTERLEAVE = 1;
	localparam int CTRL_OE = 2;
	localparam int CTRL_SLEEP = 3;
	localparam int CTRL_STALL = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

	// Command register fields: operation in the low bits, lane mask above it.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_LANE_LSB = 2;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_BURST = 2'h2;
	localparam logic [1:0] OP_DESEL = 2'h3;

	// Status register fields.
	localparam int STAT_RDVALID = 0;
	localparam int STAT_BUSY = 1;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_READ,
		KIND_WRITE
	} lws_kind_t;

	// Low address bits for step cnt of a burst that started at base.
	function automatic logic [LSB_W-1:0] lws_burst_lsbs(input logic [LSB_W-1:0] base,
		input logic [LSB_W-1:0] cnt, input logic interleave);
		lws_burst_lsbs = interleave ? (base ^ cnt) : (base + cnt);
	endfunction
endpackage

// [shared/lws_if.sv]
// Pin bundle between the memory controller and the late-write SRAM.
interface lws_if;
	import lws_pkg::*;
	logic clk_en_n;
	logic select_low_one;
	logic select_high;
	logic select_low_two;
	logic write_n;
	logic [LANES-1:0] lane_wr_n;
	logic burst_step;
	logic [ADDR_W-1:0] addr;
	logic out_en_n;
	logic sleep_req;
	logic linear_order_n;
	logic unregistered_out_n;
	logic [DATA_W-1:0] mst_dq;
	logic mst_dq_oe;
	logic [DATA_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic [DATA_W-1:0] dq_bus;

	// The shared data wire; an undriven bus reads as zero here.
	assign dq_bus = dev_dq_oe ? dev_dq : (mst_dq_oe ? mst_dq : '0);

	modport dev (
		input clk_en_n, select_low_one, select_high, select_low_two, write_n, lane_wr_n,
		input burst_step, addr, out_en_n, sleep_req, linear_order_n, unregistered_out_n,
		input dq_bus,
		output dev_dq, dev_dq_oe
	);
	modport mst (
		output clk_en_n, select_low_one, select_high, select_low_two, write_n, lane_wr_n,
		output burst_step, addr, out_en_n, sleep_req, linear_order_n, unregistered_out_n,
		output mst_dq, mst_dq_oe,
		input dq_bus
	);
endinterface

// [logic/lws_sram_dev.sv]
// Synchronous SRAM with matched read and write latency, pipelined or flow-through.
//
// Notes on behaviour
// R1: Clock enable high freezes all internal state.
// R2: Inputs sampled on rising edge, except asynchronous ones.
// R3: Master starts each new access with step low.
// R4: Selected only when all three selects active.
// R5: Second select active high, others active low.
// R6: Each byte lane enable gates its lane.
// R7: Write with no lanes enabled is a no-op.
// R8: Read captured on load with write strobe high.
// R9: Pipelined read data appears two cycles later.
// R10: Write command, address, lanes registered together.
// R11: Pipelined write data given at third edge.
// R12: Flow-through read data follows the address edge.
// R13: Flow-through write data given at second edge.
// R14: Flow-through write pipeline one cycle shorter.
// R15: Read start and counter identical in both modes.
// R16: Step high advances counter; low bits preset it.
// R17: Sleep request idles the device, clock independent.
// R18: Counter wraps after four; order select linear/interleaved.
// R19: Data drivers off during write cycles automatically.
// R20: Stall keeps read bus driven, write bus released.
// R21: Output enable off forces data pins released.
// R22: Mode select low flow-through, high pipelined.
module lws_sram_dev (
	input wire logic mclk, // system clock
	input wire logic reset_n, // asynchronous reset, active low
	lws_if.dev port // memory pins
);
	import lws_pkg::*;

	// Memory core, one word per address, written lane by lane.
	logic [DATA_W-1:0] mem [DEPTH];

	logic edge_ok;
	logic selected;
	logic flow;
	logic interleave;

	// Burst tracking.
	lws_kind_t burst_kind;
	lws_kind_t next_kind;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] next_base;
	logic [LSB_W-1:0] cnt;
	logic [LSB_W-1:0] next_cnt;

	// Command decoded at this edge.
	lws_kind_t cmd_kind;
	logic [LANES-1:0] cmd_lanes;
	logic [ADDR_W-1:0] cmd_addr;

	// Read pipeline.
	logic rd1_valid;
	logic [DATA_W-1:0] rd1_data;
	logic drive_q;
	logic [DATA_W-1:0] dq_q;
	logic [DATA_W-1:0] core_word;

	// Write pipeline.
	logic [LANES-1:0] w1_lanes;
	logic [ADDR_W-1:0] w1_addr;
	logic [LANES-1:0] w2_lanes;
	logic [ADDR_W-1:0] w2_addr;
	logic [LANES-1:0] commit_lanes;
	logic [ADDR_W-1:0] commit_addr;

	// A stalled or sleeping device sees no clock edge at all.
	assign edge_ok = !port.clk_en_n && !port.sleep_req; // R1 R17 R2

	assign selected = !port.select_low_one && port.select_high && !port.select_low_two; // R4 R5

	// The mode pin is a strap and should only change while the bus is idle.
	assign flow = !port.unregistered_out_n; // R22
	assign interleave = port.linear_order_n; // R18

	always_comb begin
		next_kind = burst_kind;
		next_base = base;
		next_cnt = cnt;
		if (!port.burst_step) begin // R3
			next_cnt = CNT_START; // R16
			next_base = port.addr; // R16
			if (!selected) begin
				next_kind = KIND_NONE; // R4
			end else if (port.write_n) begin
				next_kind = KIND_READ; // R8 R15
			end else if (&port.lane_wr_n) begin
				next_kind = KIND_NONE; // R7
			end else begin
				next_kind = KIND_WRITE; // R10
			end
		end else if (burst_kind != KIND_NONE) begin
			// Two-bit counter, so the fifth access lands on the start again.
			next_cnt = cnt + CNT_STEP; // R16 R18
		end
	end

	always_comb begin
		cmd_kind = next_kind;
		cmd_addr = {next_base[ADDR_W-1:LSB_W], lws_burst_lsbs(next_base[LSB_W-1:0], next_cnt, interleave)}; // R18
		cmd_lanes = '0;
		if (next_kind == KIND_WRITE) begin
			// An abort inside a burst still steps the counter but stores nothing.
			cmd_lanes = ~port.lane_wr_n; // R6 R7
		end
	end

	// Kind, base and counter each move only on edges the clock enable admits.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			burst_kind <= KIND_NONE;
		end else if (edge_ok) begin // R1
			burst_kind <= next_kind;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			base <= '0;
		end else if (edge_ok) begin // R1
			base <= next_base; // R16
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= CNT_START;
		end else if (edge_ok) begin // R1
			cnt <= next_cnt; // R16 R18
		end
	end

	// One core read serves both latencies; only the registers after it differ.
	assign core_word = mem[cmd_addr]; // R15

	// Read path: flow-through loads the output register at the command edge,
	// pipelined mode holds the word one more edge before it reaches the pins.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd1_valid <= 1'b0;
			rd1_data <= '0;
		end else if (edge_ok) begin // R1
			rd1_valid <= !flow && (cmd_kind == KIND_READ); // R9
			rd1_data <= core_word; // R9
		end
	end

	// Holding the drive flop on a stalled edge keeps a read on the bus.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			drive_q <= 1'b0;
		end else if (edge_ok) begin // R1 R20
			drive_q <= flow ? (cmd_kind == KIND_READ) : rd1_valid; // R12 R9 R19
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dq_q <= '0;
		end else if (edge_ok) begin // R1 R20
			dq_q <= flow ? core_word : rd1_data; // R12 R9
		end
	end

	// Write path: the command is registered at once, the data is taken one
	// edge later in flow-through mode and two edges later when pipelined.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			w1_lanes <= '0;
			w2_lanes <= '0;
		end else if (edge_ok) begin // R1
			w1_lanes <= cmd_lanes; // R10
			w2_lanes <= flow ? '0 : w1_lanes; // R14
		end
	end

	// The address rides beside the lanes so the late data finds its word.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			w1_addr <= '0;
			w2_addr <= '0;
		end else if (edge_ok) begin // R1
			w1_addr <= cmd_addr; // R10
			w2_addr <= w1_addr;
		end
	end

	assign commit_lanes = flow ? w1_lanes : w2_lanes; // R13 R14 R11
	assign commit_addr = flow ? w1_addr : w2_addr;

	// The core has no reset; its contents are undefined until written.
	always_ff @(posedge mclk) begin
		if (edge_ok) begin // R1
			for (int i = 0; i < LANES; i++) begin
				if (commit_lanes[i]) begin
					mem[commit_addr][i*LANE_W +: LANE_W] <= port.dq_bus[i*LANE_W +: LANE_W]; // R6
				end
			end
		end
	end

	// Output enable and sleep act without the clock, so this enable is gated
	// after the register; the drive itself only ever follows a read.
	assign port.dev_dq = dq_q;
	assign port.dev_dq_oe = drive_q && !port.out_en_n && !port.sleep_req; // R21 R17 R19
endmodule // lws_sram_dev

// [verif/lws_checker_properties.sv]
// Concurrent checks on the pins between the SRAM controller and the SRAM.
module lws_checker_properties (
	input wire logic mclk, // clock
	input wire logic reset_n, // reset, active low
	input wire logic clk_en_n, // stall when high
	input wire logic select_low_one, // select, low
	input wire logic select_high, // select, high
	input wire logic select_low_two, // select, low
	input wire logic write_n, // write strobe
	input wire logic [lws_pkg::LANES-1:0] lane_wr_n, // lane enables
	input wire logic burst_step, // advance or load
	input wire logic out_en_n, // output enable
	input wire logic sleep_req, // sleep
	input wire logic unregistered_out_n, // mode
	input wire logic [lws_pkg::DATA_W-1:0] dev_dq, // device data
	input wire logic dev_dq_oe, // device drive
	input wire logic mst_dq_oe // master drive
);
	import lws_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic go, sel, rd_ld, wr_ld, desel;
	assign go = !clk_en_n && !sleep_req;
	assign sel = !select_low_one && select_high && !select_low_two;
	assign rd_ld = go && sel && !burst_step && write_n;
	assign wr_ld = go && sel && !burst_step && !write_n && (lane_wr_n != '1);
	// A write with no lanes is a deselect as far as the data bus is concerned.
	assign desel = go && !burst_step && (!sel || (!write_n && lane_wr_n == '1));
	sequence s_pipe_rd; rd_ld && unregistered_out_n ##1 go; endsequence
	sequence s_pipe_wr; wr_ld && unregistered_out_n ##1 go; endsequence
	sequence s_pipe_desel; desel && unregistered_out_n ##1 go; endsequence
	property p_sleep_off; sleep_req |-> !dev_dq_oe; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("device drives in sleep");
	property p_oe_off; out_en_n |-> !dev_dq_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("device drives with output off");
	property p_pipe_rd; s_pipe_rd |=> dev_dq_oe || out_en_n || sleep_req; endproperty
	a_pipe_rd: assert property (p_pipe_rd) else $error("pipelined read not driven");
	property p_flow_rd; rd_ld && !unregistered_out_n |=> dev_dq_oe || out_en_n || sleep_req; endproperty
	a_flow_rd: assert property (p_flow_rd) else $error("flow read not driven");
	// A stall after the second edge pushes the data slot out, so a stalled edge is exempt.
	property p_pipe_wr; s_pipe_wr |=> !go || (mst_dq_oe && !dev_dq_oe); endproperty
	a_pipe_wr: assert property (p_pipe_wr) else $error("pipelined write data slot wrong");
	property p_flow_wr; wr_ld && !unregistered_out_n |=> mst_dq_oe && !dev_dq_oe; endproperty
	a_flow_wr: assert property (p_flow_wr) else $error("flow write data slot wrong");
	property p_desel; s_pipe_desel |=> !dev_dq_oe; endproperty
	a_desel: assert property (p_desel) else $error("deselect cycle drove the bus");
	property p_stall;
		clk_en_n && !sleep_req && !out_en_n |=> $stable(dev_dq) && (out_en_n || sleep_req || $stable(dev_dq_oe));
	endproperty
	a_stall: assert property (p_stall) else $error("state moved during stall");
endmodule // lws_checker_properties

// [verif/tb.sv]
// Self-checking bench joining the controller and the SRAM end to end.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lws_pkg::*;
	localparam logic [DATA_W-1:0] W_A = 36'h123456789;
	localparam logic [DATA_W-1:0] W_B = 36'hfedcba987;
	localparam logic [DATA_W-1:0] W_M = {9'h000, 9'h1ff, 9'h000, 9'h1ff};
	localparam logic [DATA_W-1:0] W_X = (W_A & ~W_M) | (W_B & W_M);
	logic mclk = 1'b0;
	logic reset_n;
	logic [REG_ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	int error_cnt = 0;
	int n_tests = 0;
	always #20 mclk = ~mclk;
	lws_if pins ();
	lws_sram_dev u_lws_sram_dev (.mclk(mclk), .reset_n(reset_n), .port(pins));
	lws_sram_mst u_lws_sram_mst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port(pins));
	lws_checker_properties u_chk (.mclk(mclk), .reset_n(reset_n), .clk_en_n(pins.clk_en_n),
		.select_low_one(pins.select_low_one), .select_high(pins.select_high), .select_low_two(pins.select_low_two),
		.write_n(pins.write_n), .lane_wr_n(pins.lane_wr_n), .burst_step(pins.burst_step), .out_en_n(pins.out_en_n),
		.sleep_req(pins.sleep_req), .unregistered_out_n(pins.unregistered_out_n), .dev_dq(pins.dev_dq),
		.dev_dq_oe(pins.dev_dq_oe), .mst_dq_oe(pins.mst_dq_oe));
	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge mclk);
	endtask
	// Bounded poll of one status bit; a stuck bit shows up as one mismatch.
	task automatic wait_stat(input int b, input logic want);
		logic [DATA_W-1:0] s;
		for (int i = 0; i < 40; i++) begin
			rd(REG_STATUS, s);
			if (s[b] === want) break;
		end
		chk("status bit", {35'h0, s[b]}, {35'h0, want});
	endtask
	task automatic mwrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [LANES-1:0] ln,
		input logic [1:0] op);
		wr(REG_ADDR, DATA_W'(a));
		wr(REG_WDATA, d);
		wr(REG_CMD, DATA_W'({ln, op}));
		wait_stat(STAT_BUSY, 1'b0);
		// Reads are not forwarded from the write pipeline, so let it drain.
		repeat (4) @(posedge mclk);
	endtask
	task automatic mread(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
		logic [DATA_W-1:0] v;
		wr(REG_ADDR, DATA_W'(a));
		wr(REG_CMD, DATA_W'(OP_READ));
		wait_stat(STAT_RDVALID, 1'b1);
		rd(REG_RDATA, v);
		chk(nm, v, e);
	endtask
	// Load and n continues on back-to-back strobes: an idle cycle in between
	// would go out as a deselect load and end the burst.
	task automatic burst_run(input logic [1:0] op, input int n, input logic walk);
		reg_addr <= REG_CMD;
		reg_wdata <= DATA_W'({walk ? 4'h1 : 4'h0, op});
		reg_wr <= 1'b1;
		for (int k = 1; k <= n; k++) begin
			@(posedge mclk);
			reg_wdata <= DATA_W'({walk ? 4'(1 << k) : 4'h0, OP_BURST});
		end
		@(posedge mclk);
		reg_wr <= 1'b0;
		repeat (7) @(posedge mclk);
	endtask
	task automatic t_regs;
		logic [DATA_W-1:0] v;
		rd(REG_CTRL, v);
		chk("ctrl reset", v, DATA_W'(CTRL_RESET));
		rd(4'hf, v);
		chk("unmapped read", v, 36'h0);
	endtask
	task automatic t_lanes;
		for (int m = 0; m < 2; m++) begin
			wr(REG_CTRL, DATA_W'(CTRL_RESET) | DATA_W'(m));
			mwrite(10'h011 + 10'(m), W_A, 4'hf, OP_WRITE);
			mwrite(10'h011 + 10'(m), W_B, 4'h5, OP_WRITE);
			mwrite(10'h011 + 10'(m), 36'h0, 4'h0, OP_WRITE);
			mread(10'h011 + 10'(m), W_X, "lane merge");
		end
	endtask
	// Base low bits of one tell the two orders apart at counter values one and three.
	task automatic t_burst;
		logic [1:0] l;
		logic [DATA_W-1:0] v;
		logic [DATA_W-1:0] w;
		for (int o = 0; o < 2; o++) begin
			w = (o != 0) ? W_B : W_A;
			wr(REG_CTRL, DATA_W'(CTRL_RESET) | DATA_W'(o << CTRL_INTERLEAVE));
			for (int k = 0; k < 4; k++) begin
				mwrite({8'h29, 2'(k)}, 36'h0, 4'hf, OP_WRITE);
			end
			wr(REG_ADDR, DATA_W'(10'h0a5));
			wr(REG_WDATA, w);
			burst_run(OP_WRITE, 3, 1'b1);
			for (int k = 0; k < 4; k++) begin
				l = (o != 0) ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
				mread({8'h29, l}, w & (DATA_W'(9'h1ff) << (LANE_W * k)), "burst word");
			end
			wr(REG_ADDR, DATA_W'(10'h0a5));
			for (int k = 0; k < 5; k++) begin
				burst_run(OP_READ, k, 1'b0);
				rd(REG_RDATA, v);
				chk("burst read", v, w & (DATA_W'(9'h1ff) << (LANE_W * (k % 4))));
			end
		end
	endtask
	task automatic t_hold;
		wr(REG_CTRL, DATA_W'(CTRL_RESET) | 36'h10);
		mwrite(10'h011, 36'h0, 4'hf, OP_WRITE);
		wr(REG_CTRL, DATA_W'(CTRL_RESET) | 36'h08);
		mwrite(10'h012, 36'h0, 4'hf, OP_WRITE);
		wr(REG_CTRL, DATA_W'(CTRL_RESET));
		mread(10'h011, W_X, "after stall");
		mread(10'h012, W_X, "after sleep");
		wr(REG_CTRL, 36'h0);
		// With the drivers off the bus resolves to zero, so the read sees zero.
		mread(10'h011, 36'h0, "output off");
		wr(REG_CTRL, DATA_W'(CTRL_RESET));
	endtask
	// The stall lands one strobe after the write, so it is frozen mid-pipeline.
	task automatic t_stall;
		wr(REG_ADDR, DATA_W'(10'h013));
		wr(REG_WDATA, W_B);
		reg_addr <= REG_CMD;
		reg_wdata <= DATA_W'({4'hf, OP_WRITE});
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_addr <= REG_CTRL;
		reg_wdata <= DATA_W'(CTRL_RESET) | 36'h10;
		@(posedge mclk);
		reg_wr <= 1'b0;
		repeat (6) @(posedge mclk);
		wr(REG_CTRL, DATA_W'(CTRL_RESET));
		repeat (4) @(posedge mclk);
		mread(10'h013, W_B, "stalled write");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_lanes();
		t_burst();
		t_hold();
		t_stall();
		end_sim();
	end
	initial begin
		#(40 * 20000);
		error_cnt++;
		end_sim();
	end
endmodule // tb
